// >>> dv/tb_top.sv
// bench top: slave, serial master model and a stalling write sink
// assumes the data pin has a pull-up and the strap level is high
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        writeReady = 1'b1;
    logic        busRequestIn = 1'b0;
    logic        sclk, mDat, line, oeN, dOut, portEnabled, readStrobe;
    logic        writeValid, cpuHalt, busGrantPermit;
    logic        busGrantOut, busGrantStatus;
    logic [6:0]  debugAddr, writeAddr;
    logic [7:0]  readData, writeData, b;
    logic [14:0] wq[$];
    int          n_errors = 0;
    int          checked = 0;
    int          cyc = 0;

    always #5 ref_clk = ~ref_clk;
    // wired level: low when either side pulls low
    assign line = mDat & (oeN | dOut);
    assign readData = {1'b0, debugAddr} ^ 8'h3C;
    // sink stalls 8 of 32 cycles, well below a byte time
    always @(negedge ref_clk) begin
        cyc <= cyc + 1;
        writeReady <= (cyc[4:3] != 2'b11);
    end
    // collect taken write words
    always @(posedge ref_clk)
        if (!rst && writeValid === 1'b1 && writeReady)
            wq.push_back({writeAddr, writeData});

    tdbg_dbg_master i_mst (.ref_clk, .line, .sclk, .mDat);
    tdbg_slave i_dut (
        .ref_clk, .rst,
        .debugSerialClock(sclk), .debugSerialDataIn(line),
        .debugSerialDataOut(dOut), .debugSerialDataOeN(oeN),
        .portEnabled, .debugAddr, .readStrobe, .readData,
        .writeValid, .writeReady, .writeAddr, .writeData,
        .cpuHalt, .busGrantPermit, .busRequestIn,
        .busGrantOut, .busGrantStatus
    );

    task chk(input string nm, input logic [14:0] e, input logic [14:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task test_done();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // next taken word, bounded wait
    task expW(input logic [14:0] e);
        int i;
        for (i = 0; i < 400 && wq.size() == 0; i++) @(negedge ref_clk);
        if (wq.size() == 0) begin
            chk("write word", e, ~e);
            test_done();
        end else
            chk("write word", e, wq.pop_front());
    endtask
    task waitG(input logic e);
        int i;
        for (i = 0; i < 40 && busGrantOut !== e; i++) @(negedge ref_clk);
        chk("grant pin", e, busGrantOut);
        chk("grant status", e, busGrantStatus);
        if (busGrantOut !== e) test_done();
    endtask
    task rd(input logic [7:0] e, input logic sep, input logic [7:0] m);
        i_mst.rdByte(b, sep);
        chk("read byte", e & m, b & m);
    endtask

    initial begin
        repeat (15) @(negedge ref_clk);
        chk("reset outputs", 15'h0020, {oeN, busGrantOut,
            busGrantPermit, cpuHalt, writeValid, portEnabled});
        @(negedge ref_clk) rst <= 1'b0;
        repeat (10) @(negedge ref_clk);
        chk("strap enable", 1, portEnabled);
        $display("test reset done");
        i_mst.noise();
        i_mst.wrByte({7'h20, 1'b0}, 1'b0);
        i_mst.wrByte(8'h55, 1'b1);
        repeat (20) @(negedge ref_clk);
        chk("ignored traffic", 0, {14'h0, wq.size() != 0});
        $display("test no start done");
        i_mst.start();
        i_mst.wrByte({7'h2F, 1'b0}, 1'b0);
        i_mst.wrByte(8'hA1, 1'b0);
        i_mst.wrByte(8'hB2, 1'b1);
        i_mst.wrByte(8'hC3, 1'b1);
        expW({7'h2F, 8'hA1});
        expW({7'h30, 8'hB2});
        expW({7'h30, 8'hC3});
        $display("test block write done");
        i_mst.start();
        i_mst.wrByte({7'h00, 1'b0}, 1'b0);
        i_mst.wrByte(8'h3C, 1'b1);
        expW({7'h00, 8'h3C});
        i_mst.start();
        i_mst.wrByte({7'h00, 1'b1}, 1'b0);
        rd(8'hA5, 1'b0, 8'hFF);
        rd(8'h5A, 1'b0, 8'hFF);
        rd(8'h01, 1'b1, 8'hFF);
        i_mst.start();
        i_mst.wrByte({7'h1F, 1'b1}, 1'b0);
        rd(8'h23, 1'b0, 8'hFF);
        rd(8'h1C, 1'b0, 8'hFF);
        rd(8'h1C, 1'b1, 8'hFF);
        $display("test reads done");
        for (int k = 1; k >= 0; k--) begin
            i_mst.start();
            i_mst.wrByte({7'h10, 1'b0}, 1'b0);
            i_mst.wrByte({k[0], 7'h00}, 1'b1);
            expW({7'h10, k[0], 7'h00});
            repeat (20) @(negedge ref_clk);
            chk("cpu halt", k[0], cpuHalt);
        end
        $display("test halt done");
        busRequestIn <= 1'b1;
        repeat (10) @(negedge ref_clk);
        chk("grant before permit", 0, busGrantOut);
        i_mst.start();
        i_mst.wrByte({7'h17, 1'b0}, 1'b0);
        i_mst.wrByte(8'h80, 1'b1);
        expW({7'h17, 8'h80});
        chk("grant permit", 1, busGrantPermit);
        waitG(1'b1);
        i_mst.start();
        i_mst.wrByte({7'h17, 1'b1}, 1'b0);
        chk("grant mid command", 0, busGrantOut);
        rd(8'h00, 1'b1, 8'h80);
        waitG(1'b1);
        i_mst.start();
        i_mst.wrByte({7'h17, 1'b1}, 1'b1);
        rd(8'h80, 1'b1, 8'h80);
        @(negedge ref_clk) busRequestIn <= 1'b0;
        waitG(1'b0);
        $display("test bus grant done");
        test_done();
    end
    // run limit against a hung sequence
    initial begin
        #500000;
        $display("[FAIL] run time expected end seen limit");
        n_errors++;
        test_done();
    end
endmodule

// >>> dv/tdbg_checker.sv
// port checks for the serial debug slave
// assumes one clock domain with a synchronous active-high reset
module tdbg_checker (
    input logic       ref_clk,
    input logic       rst,
    input logic       debugSerialClock,
    input logic       debugSerialDataOeN,
    input logic       portEnabled,
    input logic       readStrobe,
    input logic       writeValid,
    input logic       writeReady,
    input logic [6:0] writeAddr,
    input logic [7:0] writeData,
    input logic       busGrantPermit,
    input logic       busRequestIn,
    input logic       busGrantOut,
    input logic       busGrantStatus
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // request gone long enough to clear the synchroniser
    sequence s_req_gone;
        !busRequestIn [*6];
    endsequence
    sequence s_head_stalled;
        writeValid && !writeReady;
    endsequence
    a_status_pin: assert property (
        busGrantStatus == busGrantOut) else $error("status differs from pin");
    a_grant_permit: assert property (
        busGrantOut |-> $past(busGrantPermit)) else $error("grant unpermitted");
    a_grant_request: assert property (
        s_req_gone |-> !busGrantOut) else $error("grant without request");
    a_off_released: assert property (
        !portEnabled |-> debugSerialDataOeN) else $error("disabled port drives");
    a_drive_fall: assert property (
        $fell(debugSerialDataOeN) |-> !$past(debugSerialClock, 2))
        else $error("data driven outside clock low");
    a_strobe_load: assert property (
        readStrobe |-> $fell(debugSerialDataOeN))
        else $error("read load not at first drive");
    a_load_strobe: assert property (
        $fell(debugSerialDataOeN) |-> readStrobe)
        else $error("first drive without read load");
    a_strobe_pulse: assert property (
        readStrobe |=> !readStrobe) else $error("read strobe too long");
    a_head_holds: assert property (
        s_head_stalled |=> writeValid && $stable(writeAddr)
        && $stable(writeData)) else $error("stalled write word changed");
endmodule

bind tdbg_slave tdbg_checker i_chk (
    .ref_clk, .rst, .debugSerialClock, .debugSerialDataOeN,
    .portEnabled, .readStrobe, .writeValid, .writeReady,
    .writeAddr, .writeData, .busGrantPermit, .busRequestIn,
    .busGrantOut, .busGrantStatus
);

// >>> dv/tdbg_dbg_master.sv
// serial debug master model: drives clock and data lines
// assumes the bench resolves the data wire with a pull-up
module tdbg_dbg_master (
    input  logic ref_clk,
    input  logic line,
    output logic sclk,
    output logic mDat
);
    timeunit 1ns;
    timeprecision 1ns;
    // clock parked high; data starts released, then holds the last level driven
    initial begin
        sclk = 1'b1;
        mDat = 1'b1;
    end
    // data moves only while the clock is low, 80 ns period
    task bitOut(input logic v);
        sclk = 1'b0;
        #20 mDat = v;
        #20 sclk = 1'b1;
        #40;
    endtask
    // data falls with clock high; offset keeps edges off ref_clk
    task start();
        @(posedge ref_clk);
        #3 mDat = 1'b1;
        #40 mDat = 1'b0;
        #40;
    endtask
    // msb first, eight bits, then the separator
    task wrByte(input logic [7:0] v, input logic sep);
        for (int i = 7; i >= 0; i--) bitOut(v[i]);
        bitOut(sep);
    endtask
    // line released, slave bit taken at each rising edge
    task rdByte(output logic [7:0] v, input logic sep);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            #20 mDat = 1'b1;
            #20 sclk = 1'b1;
            v[i] = line;
            #40;
        end
        bitOut(sep);
    endtask
    // a data rise while the clock is high, no start before it
    task noise();
        bitOut(1'b0);
        mDat = 1'b1;
        #40;
    endtask
endmodule

// >>> rtl/tdbg_defs.vh
// constants of the two-wire debug slave: offsets, field bits, resets
// assumes inclusion by bare name from the rtl files of the block
`ifndef TDBG_DEFS_VH
`define TDBG_DEFS_VH

// widths of the debug register space
`define TDBG_ADDR_W        7
`define TDBG_DATA_W        8
`define TDBG_WORD_W        15

// bit count values at the separator and the last data bit of a frame
`define TDBG_SEP_CNT       4'h8
`define TDBG_LAST_BIT_CNT  4'h7

// end of the write-only and read-only address spaces
`define TDBG_WR_END        7'h30
`define TDBG_RD_END        7'h20

// registers decoded inside the block
`define TDBG_REG_ID_LOW    7'h00
`define TDBG_REG_ID_HIGH   7'h01
`define TDBG_REG_ID_REV    7'h02
`define TDBG_REG_BRK_CTL   7'h10
`define TDBG_REG_BUS_CTL   7'h17
`define TDBG_REG_BUS_STAT  7'h17

// field positions and reset values
`define TDBG_BRK_HALT_BIT  7
`define TDBG_BUS_PERMIT_BIT 7
`define TDBG_BUS_STAT_BIT  7
`define TDBG_BYTE_RESET    8'h00

// system cycles after reset release before the strap is taken
`define TDBG_STRAP_WAIT    2'h3

`endif

// >>> rtl/tdbg_pair_buffer.v
// two-entry buffer with valid and ready on both sides
// assumes one clock and a synchronous active-high reset
`include "tdbg_defs.vh"

module tdbg_pair_buffer #(
    parameter WIDTH = `TDBG_WORD_W
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire             inValid,
    output reg              inReady,
    input  wire [WIDTH-1:0] inData,
    output reg              outValid,
    input  wire             outReady,
    output reg  [WIDTH-1:0] outData
);

    reg             tailValid;
    reg [WIDTH-1:0] tailData;
    reg             next_headValid;
    reg             next_tailValid;
    reg [WIDTH-1:0] next_headData;
    reg [WIDTH-1:0] next_tailData;
    reg             popNow;
    reg             pushNow;

    // head is the output register, tail catches a word during a stall
    always @* begin
        next_headValid = outValid;
        next_tailValid = tailValid;
        next_headData  = outData;
        next_tailData  = tailData;
        popNow         = outValid & outReady;
        pushNow        = inValid & inReady;
        if (popNow) begin
            next_headValid = tailValid;
            next_headData  = tailData;
            next_tailValid = 1'b0;
        end
        if (pushNow) begin
            if (!next_headValid) begin
                next_headValid = 1'b1;
                next_headData  = inData;
            end else begin
                next_tailValid = 1'b1;
                next_tailData  = inData;
            end
        end
    end

    // ready is registered so the filling side sees a clean level
    always @(posedge ref_clk) begin
        if (rst) begin
            outValid  <= 1'b0;
            tailValid <= 1'b0;
            inReady   <= 1'b1;
            outData   <= {WIDTH{1'b0}};
            tailData  <= {WIDTH{1'b0}};
        end else begin
            outValid  <= next_headValid;
            tailValid <= next_tailValid;
            inReady   <= ~next_tailValid;
            outData   <= next_headData;
            tailData  <= next_tailData;
        end
    end

endmodule

// >>> rtl/tdbg_slave.v
// two-wire serial debug slave: start detect, address, byte frames
// assumes lines come from pins, register side runs on ref_clk
// assumes the debug clock runs at most half the ref_clk rate
`include "tdbg_defs.vh"

module tdbg_slave #(
    parameter [7:0] ID_LOW  = 8'hA5, // arbitrary identification value
    parameter [7:0] ID_HIGH = 8'h5A, // arbitrary identification value
    parameter [7:0] ID_REV  = 8'h01  // arbitrary revision value
) (
    input  wire                     ref_clk,
    input  wire                     rst,
    input  wire                     debugSerialClock,
    input  wire                     debugSerialDataIn,
    output reg                      debugSerialDataOut,
    output reg                      debugSerialDataOeN,
    output reg                      portEnabled,
    output reg  [`TDBG_ADDR_W-1:0]  debugAddr,
    output reg                      readStrobe,
    input  wire [`TDBG_DATA_W-1:0]  readData,
    output wire                     writeValid,
    input  wire                     writeReady,
    output wire [`TDBG_ADDR_W-1:0]  writeAddr,
    output wire [`TDBG_DATA_W-1:0]  writeData,
    output reg                      cpuHalt,
    output reg                      busGrantPermit,
    input  wire                     busRequestIn,
    output reg                      busGrantOut,
    output reg                      busGrantStatus
);

    // frame states
    // idle waits for start; address byte, then write or read frames
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_ADDR  = 2'h1;
    localparam [1:0] ST_WRITE = 2'h2;
    localparam [1:0] ST_READ  = 2'h3;

    // pin samples, frame position and the held write word
    reg                    sclMeta;
    reg                    sclSync;
    reg                    sclLast;
    reg                    sdaMeta;
    reg                    sdaSync;
    reg                    sdaLast;
    reg                    reqMeta;
    reg                    reqSync;
    reg [1:0]              strapCnt;
    reg                    strapDone;
    reg [1:0]              state;
    reg [3:0]              bitCnt;
    reg [`TDBG_DATA_W-1:0] shiftIn;
    reg [`TDBG_DATA_W-1:0] shiftOut;
    reg                    opDone;
    reg                    pushPend;
    reg [`TDBG_WORD_W-1:0] pendWord;
    reg [`TDBG_DATA_W-1:0] readByte;
    reg                    next_grant;

    // strobes derived from the synchronised samples
    wire                    sclRise;
    wire                    sclFall;
    wire                    startSeen;
    wire                    sepRise;
    wire                    pushNow;
    wire                    bufInReady;
    wire [`TDBG_DATA_W-1:0] newByte;
    wire [`TDBG_WORD_W-1:0] bufOut;

    // two flops per pin; only the second stage feeds any logic
    // a pin edge near ref_clk must never reach two decisions at once
    always @(posedge ref_clk) begin
        if (rst) begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            reqMeta <= 1'b0;
            reqSync <= 1'b0;
        end else begin
            sclMeta <= debugSerialClock;
            sclSync <= sclMeta;
            sdaMeta <= debugSerialDataIn;
            sdaSync <= sdaMeta;
            reqMeta <= busRequestIn;
            reqSync <= reqMeta;
        end
    end

    // previous synced samples for edge detection
    // reset to the idle high level so no false edge follows reset
    always @(posedge ref_clk) begin
        if (rst) begin
            sclLast <= 1'b1;
            sdaLast <= 1'b1;
        end else begin
            sclLast <= sclSync;
            sdaLast <= sdaSync;
        end
    end

    // edges need the clock to run at most half the system rate
    assign sclRise = sclSync & ~sclLast;
    assign sclFall = ~sclSync & sclLast;
    // only a falling data edge under a steady high clock starts a command
    assign startSeen = portEnabled & sclSync & sclLast &
                       sdaLast & ~sdaSync;
    // ninth rise of a frame carries the separator bit
    assign sepRise = sclRise & (bitCnt == `TDBG_SEP_CNT);
    // bits enter at the low end, so the first one lands in bit 7
    assign newByte = {shiftIn[6:0], sdaSync};

    // strap taken a few cycles after release, once the sync chain is real
    // limitation: the level is taken once and held until the next reset
    always @(posedge ref_clk) begin
        if (rst) begin
            strapCnt    <= 2'h0;
            strapDone   <= 1'b0;
            portEnabled <= 1'b0;
        end else if (!strapDone) begin
            if (strapCnt == `TDBG_STRAP_WAIT) begin
                portEnabled <= sclSync;
                strapDone   <= 1'b1;
            end else begin
                strapCnt <= strapCnt + 2'h1;
            end
        end
    end

    // a whole byte was received during a write frame
    assign pushNow = portEnabled & ~startSeen & (state == ST_WRITE) &
                     sclRise & (bitCnt == `TDBG_LAST_BIT_CNT);

    // read-only decode; addresses not held here come from outside
    // the same address may mean another register when written
    always @* begin
        readByte = readData;
        case (debugAddr)
            `TDBG_REG_ID_LOW: begin
                readByte = ID_LOW;
            end
            `TDBG_REG_ID_HIGH: begin
                readByte = ID_HIGH;
            end
            `TDBG_REG_ID_REV: begin
                readByte = ID_REV;
            end
            `TDBG_REG_BUS_STAT: begin
                readByte = `TDBG_BYTE_RESET;
                readByte[`TDBG_BUS_STAT_BIT] = busGrantStatus;
            end
            default: begin
                readByte = readData;
            end
        endcase
    end

    // frame sequencer: address byte, then repeated data frames
    // a new start wins over any frame in flight and restarts the count
    always @(posedge ref_clk) begin
        if (rst) begin
            state              <= ST_IDLE;
            bitCnt             <= 4'h0;
            shiftIn            <= `TDBG_BYTE_RESET;
            shiftOut           <= `TDBG_BYTE_RESET;
            debugAddr          <= {`TDBG_ADDR_W{1'b0}};
            debugSerialDataOut <= 1'b1;
            debugSerialDataOeN <= 1'b1;
            readStrobe         <= 1'b0;
            opDone             <= 1'b1;
        end else if (!portEnabled) begin
            // port stays deaf while the other debug block owns the pins
            state              <= ST_IDLE;
            debugSerialDataOeN <= 1'b1;
            readStrobe         <= 1'b0;
        end else if (startSeen) begin
            state              <= ST_ADDR;
            bitCnt             <= 4'h0;
            debugSerialDataOeN <= 1'b1;
            debugSerialDataOut <= 1'b1;
            readStrobe         <= 1'b0;
            opDone             <= 1'b0;
        end else begin
            readStrobe <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // deaf until a start; stray clocks are ignored
                    bitCnt <= 4'h0;
                end
                ST_ADDR: begin
                    if (sepRise) begin
                        // seven address bits then the direction bit
                        debugAddr <= shiftIn[7:1];
                        state     <= shiftIn[0] ? ST_READ : ST_WRITE;
                        bitCnt    <= 4'h0;
                        opDone    <= sdaSync;
                    end else if (sclRise) begin
                        shiftIn <= newByte;
                        bitCnt  <= bitCnt + 4'h1;
                    end
                end
                ST_WRITE: begin
                    if (sepRise) begin
                        // no start: stay in write, block transfer
                        bitCnt <= 4'h0;
                        opDone <= sdaSync;
                        if (debugAddr != `TDBG_WR_END) begin
                            debugAddr <= debugAddr + 7'h01;
                        end
                    end else if (sclRise) begin
                        shiftIn <= newByte;
                        bitCnt  <= bitCnt + 4'h1;
                    end
                end
                ST_READ: begin
                    if (sepRise) begin
                        bitCnt <= 4'h0;
                        opDone <= sdaSync;
                        if (debugAddr != `TDBG_RD_END) begin
                            debugAddr <= debugAddr + 7'h01;
                        end
                    end else if (sclRise) begin
                        bitCnt <= bitCnt + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt == 4'h0) begin
                            // first low phase after the separator
                            shiftOut           <= {readByte[6:0], 1'b0};
                            debugSerialDataOut <= readByte[7];
                            debugSerialDataOeN <= 1'b0;
                            readStrobe         <= 1'b1;
                        end else if (bitCnt == `TDBG_SEP_CNT) begin
                            // separator belongs to the master
                            debugSerialDataOeN <= 1'b1;
                            debugSerialDataOut <= 1'b1;
                        end else begin
                            debugSerialDataOut <= shiftOut[7];
                            shiftOut <= {shiftOut[6:0], 1'b0};
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // one word held while the buffer is full; a frame is far longer
    // than the drain time, so a stall only delays the word
    // limitation: a longer stall lets a newer byte replace the held one
    always @(posedge ref_clk) begin
        if (rst) begin
            pushPend <= 1'b0;
            pendWord <= {`TDBG_WORD_W{1'b0}};
        end else if (pushNow) begin
            pushPend <= 1'b1;
            pendWord <= {debugAddr, newByte};
        end else if (pushPend && bufInReady) begin
            pushPend <= 1'b0;
        end
    end

    // every write leaves as an ordinary register write
    // the buffer absorbs a short stall by the receiving side
    tdbg_pair_buffer #(
        .WIDTH    (`TDBG_WORD_W)
    ) writeBuf (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .inValid  (pushPend),
        .inReady  (bufInReady),
        .inData   (pendWord),
        .outValid (writeValid),
        .outReady (writeReady),
        .outData  (bufOut)
    );

    assign writeAddr = bufOut[`TDBG_WORD_W-1:`TDBG_DATA_W];
    assign writeData = bufOut[`TDBG_DATA_W-1:0];

    // write-only controls decoded here as well as sent outward
    // decoded from the live byte so a stalled receiver cannot delay them
    always @(posedge ref_clk) begin
        if (rst) begin
            cpuHalt        <= 1'b0;
            busGrantPermit <= 1'b0;
        end else if (pushNow) begin
            if (debugAddr == `TDBG_REG_BRK_CTL) begin
                // halt reaches only the cpu; clocks stay free
                cpuHalt <= newByte[`TDBG_BRK_HALT_BIT];
            end
            if (debugAddr == `TDBG_REG_BUS_CTL) begin
                busGrantPermit <= newByte[`TDBG_BUS_PERMIT_BIT];
            end
        end
    end

    // grant needs the permit, a live request and no operation in flight;
    // the separator of each byte tells where an operation ends
    always @* begin
        next_grant = 1'b0;
        if (busGrantPermit && reqSync) begin
            next_grant = opDone;
        end
    end

    // both copies from one next value so pin and status never differ
    always @(posedge ref_clk) begin
        if (rst) begin
            busGrantOut    <= 1'b0;
            busGrantStatus <= 1'b0;
        end else begin
            busGrantOut    <= next_grant;
            busGrantStatus <= next_grant;
        end
    end

endmodule
